// ---- hw/acr_pkg.sv ----
// acr_pkg: constants and types for the converter control block
// assumes a 10 MHz mclk and an APB register bus
package acr_pkg;
  // register byte offsets
  localparam logic [7:0] ACR_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] ACR_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] ACR_OFF_RESH = 8'h08;
  localparam logic [7:0] ACR_OFF_RESL = 8'h0C;
  localparam logic [7:0] ACR_OFF_STAT = 8'h10;
  // reset values
  localparam logic [7:0] ACR_CTRL0_RST = 8'h00;
  localparam logic [7:0] ACR_CTRL1_RST = 8'h00;
  // control 0 field positions
  localparam int ACR_C0_ON = 0;
  localparam int ACR_C0_GO = 1;
  localparam int ACR_C0_CHS_LO = 2;
  // control 1 field positions
  localparam int ACR_C1_REF_LO = 0;
  localparam int ACR_C1_CKS_LO = 4;
  localparam int ACR_C1_JUST = 7;
  // implemented-bit masks
  localparam logic [7:0] ACR_CTRL0_MASK = 8'h7F;
  localparam logic [7:0] ACR_CTRL1_MASK = 8'hF3;
  // channel codes
  localparam logic [4:0] ACR_CH_LAST_EXT = 5'h0D;
  localparam logic [4:0] ACR_CH_TEMP = 5'h1D;
  localparam logic [4:0] ACR_CH_FVR = 5'h1F;
  // reference codes
  localparam logic [1:0] ACR_REF_SUPPLY = 2'h0;
  localparam logic [1:0] ACR_REF_PIN = 2'h2;
  // conversion timing: 11.5 periods = 23 half periods
  localparam int ACR_RES_BITS = 10;
  localparam logic [4:0] ACR_CONV_HALVES = 5'h17;
  localparam int ACR_CLK_MHZ = 10;
  localparam int ACR_DIV_W = 6;

  typedef enum logic [1:0] {ACR_IDLE, ACR_CONV} acr_state_t;

  typedef struct packed {
    logic [4:0] chan;
    logic enable;
  } acr_chan_t;
endpackage

// ---- hw/acr_tick.sv ----
// acr_tick: half-period enable generator for the conversion clock
// assumes rc_tick is already synchronous to mclk
`timescale 1ns/1ns
module acr_tick
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic rc_tick,
  output logic tick
);
  typedef struct packed {
    logic [ACR_DIV_W-1:0] cnt;
    logic tick;
  } acr_tick_st_t;
  acr_tick_st_t st, next_st;
  logic [ACR_DIV_W-1:0] half;

  // -------------------------
  // divider
  // -------------------------
  always_comb begin
    unique case (sel)
      3'h0: half = 6'h00;
      3'h4: half = 6'h01;
      3'h1: half = 6'h03;
      3'h5: half = 6'h07;
      3'h2: half = 6'h0F;
      3'h6: half = 6'h1F;
      default: half = 6'h00;
    endcase
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.cnt = '0;
    end else if (sel[1:0] == 2'h3) begin
      next_st.tick = rc_tick;
    end else if (st.cnt >= half) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // acr_tick

// ---- hw/acr_top.sv ----
// acr_top: converter control and result registers on APB
// assumes an analog core that reports one comparator decision per bit
//
// Functional notes
// - five-bit channel select, codes 0-13 external
// - temperature 11101, reference 11111, others none
// - writing start begins conversion, reads busy
// - hardware clears start bit at completion
// - enable bit powers converter, zero powers off
// - three-bit clock select divider or RC
// - reference select supply or pin, rest reserved
// - right justified zeroes high upper six bits
// - left justified zeroes low lower six bits
// - left format high holds bits 9-2
// - right format low holds bits 7-0
// - unimplemented control bits read zero
// - control resets zero, results keep value
// - completion clears start, sets flag, loads result
// - abort loads partial result, last bit repeated
// - conversion lasts eleven and half periods
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module acr_top
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clk_pin,
  input wire logic comp_out,
  output logic core_power,
  output logic [4:0] core_channel,
  output logic core_channel_valid,
  output logic core_sample,
  output logic [ACR_RES_BITS-1:0] core_trial,
  output logic [1:0] core_ref_sel,
  output logic conversion_done_flag
);
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] resh;
    logic [7:0] resl;
    acr_state_t state;
    logic [2:0] cks;
    logic [4:0] halves;
    logic [3:0] bitn;
    logic [ACR_RES_BITS-1:0] sar;
    logic done_flag;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic comp_q;
    logic [2:0] rc_sync;
    logic core_sample;
    logic [ACR_RES_BITS-1:0] trial;
    logic [4:0] chan;
    logic chan_valid;
  } acr_st_t;
  acr_st_t st, next_st;
  logic tick;
  logic rc_tick;
  logic wr_acc;
  logic rd_acc;
  logic [ACR_RES_BITS-1:0] fin;

  assign rc_tick = st.rc_sync[2] ^ st.rc_sync[1];

  acr_tick u_tick (
    .mclk(mclk),
    .reset(reset),
    .run(st.state == ACR_CONV),
    .sel(st.cks),
    .rc_tick(rc_tick),
    .tick(tick)
  );

  // -------------------------
  // helpers
  // -------------------------
  // fill unresolved bits
  function automatic logic [ACR_RES_BITS-1:0] fill_partial(
    input logic [ACR_RES_BITS-1:0] v, input logic [3:0] n);
    logic [ACR_RES_BITS-1:0] r;
    logic last;
    r = v;
    last = (n == 4'h0) ? 1'b0 : v[ACR_RES_BITS - int'(n)];
    for (int i = 0; i < ACR_RES_BITS; i++) begin
      if (i < ACR_RES_BITS - int'(n)) begin
        r[i] = last;
      end
    end
    return r;
  endfunction

  // -------------------------
  // next state
  // -------------------------
  always_comb begin
    next_st = st;
    fin = '0;
    wr_acc = psel && penable && pwrite && !st.pready;
    rd_acc = psel && penable && !pwrite && !st.pready;
    next_st.pready = psel && penable && !st.pready;
    next_st.pslverr = 1'b0;
    // core answers the registered trial within one mclk
    next_st.comp_q = comp_out;
    next_st.rc_sync = {st.rc_sync[1:0], rc_clk_pin};
    next_st.core_sample = 1'b0;
    next_st.chan = st.ctrl0[6:2];
    next_st.chan_valid = (st.ctrl0[6:2] <= ACR_CH_LAST_EXT) ||
      (st.ctrl0[6:2] == ACR_CH_TEMP) || (st.ctrl0[6:2] == ACR_CH_FVR);
    // bus read
    if (rd_acc) begin
      unique case (paddr)
        ACR_OFF_CTRL0: next_st.prdata = {24'h000000, st.ctrl0};
        ACR_OFF_CTRL1: next_st.prdata = {24'h000000, st.ctrl1};
        ACR_OFF_RESH: next_st.prdata = {24'h000000, st.resh};
        ACR_OFF_RESL: next_st.prdata = {24'h000000, st.resl};
        ACR_OFF_STAT: next_st.prdata = {31'h00000000, st.done_flag};
        default: begin
          next_st.prdata = 32'h00000000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end else begin
      next_st.prdata = 32'h00000000;
    end
    // bus write
    if (wr_acc) begin
      unique case (paddr)
        ACR_OFF_CTRL0: next_st.ctrl0 = pwdata[7:0] & ACR_CTRL0_MASK;
        ACR_OFF_CTRL1: next_st.ctrl1 = pwdata[7:0] & ACR_CTRL1_MASK;
        ACR_OFF_RESH: next_st.resh = pwdata[7:0];
        ACR_OFF_RESL: next_st.resl = pwdata[7:0];
        ACR_OFF_STAT: begin
          if (pwdata[0]) begin
            next_st.done_flag = 1'b0;
          end
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
    // conversion sequencer
    unique case (st.state)
      ACR_IDLE: begin
        if (next_st.ctrl0[ACR_C0_GO] && st.ctrl0[ACR_C0_ON]) begin
          next_st.state = ACR_CONV;
          next_st.cks = st.ctrl1[6:4];
          next_st.halves = '0;
          next_st.bitn = '0;
          next_st.sar = '0;
          next_st.trial = 10'h200;
          next_st.core_sample = 1'b1;
        end else begin
          next_st.ctrl0[ACR_C0_GO] = 1'b0;
        end
      end
      ACR_CONV: begin
        if (!next_st.ctrl0[ACR_C0_GO] || !next_st.ctrl0[ACR_C0_ON]) begin
          fin = fill_partial(st.sar, st.bitn);
          next_st.state = ACR_IDLE;
          next_st.ctrl0[ACR_C0_GO] = 1'b0;
        end else if (tick) begin
          next_st.halves = st.halves + 5'h01;
          // one bit per period msb first
          if (st.halves[0] && st.halves >= 5'h03 &&
              st.bitn < 4'(ACR_RES_BITS)) begin
            next_st.sar[ACR_RES_BITS - 1 - int'(st.bitn)] = st.comp_q;
            next_st.bitn = st.bitn + 4'h1;
            next_st.trial = next_st.sar;
            if (st.bitn < 4'(ACR_RES_BITS - 1)) begin
              next_st.trial[ACR_RES_BITS - 2 - int'(st.bitn)] = 1'b1;
            end
          end
          if (st.halves == ACR_CONV_HALVES - 5'h01) begin
            fin = next_st.sar;
            next_st.state = ACR_IDLE;
            next_st.ctrl0[ACR_C0_GO] = 1'b0;
          end
        end
      end
    endcase
    if (st.state == ACR_CONV && next_st.state == ACR_IDLE) begin
      next_st.done_flag = 1'b1;
      if (st.ctrl1[ACR_C1_JUST]) begin
        next_st.resh = {6'h00, fin[9:8]};
        next_st.resl = fin[7:0];
      end else begin
        next_st.resh = fin[9:2];
        next_st.resl = {fin[1:0], 6'h00};
      end
    end
  end

  // -------------------------
  // registers
  // -------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st.ctrl0 <= ACR_CTRL0_RST;
      st.ctrl1 <= ACR_CTRL1_RST;
      st.resh <= st.resh;
      st.resl <= st.resl;
      st.state <= ACR_IDLE;
      st.cks <= '0;
      st.halves <= '0;
      st.bitn <= '0;
      st.sar <= '0;
      st.done_flag <= 1'b0;
      st.prdata <= '0;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.comp_q <= 1'b0;
      st.rc_sync <= '0;
      st.core_sample <= 1'b0;
      st.trial <= '0;
      st.chan <= '0;
      // channel zero after reset is a valid input
      st.chan_valid <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------
  // outputs
  // -------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign core_power = st.ctrl0[ACR_C0_ON];
  assign core_channel = st.chan;
  assign core_channel_valid = st.chan_valid;
  assign core_sample = st.core_sample;
  assign core_trial = st.trial;
  assign core_ref_sel = st.ctrl1[1:0];
  assign conversion_done_flag = st.done_flag;
endmodule // acr_top

// ---- tb/acr_core_model.sv ----
// acr_core_model: comparator of the analog core
// assumes the trial word holds between bit decisions
`timescale 1ns/1ns
module acr_core_model (
  input wire logic [9:0] lvl,
  input wire logic [9:0] core_trial,
  input wire logic core_power,
  output logic comp_out
);
  assign comp_out = core_power & (core_trial <= lvl);
endmodule // acr_core_model

// ---- tb/acr_sva.sv ----
// acr_sva: bus timing, read field, channel map and sample pulse checks
// assumes the bind below onto acr_top
`timescale 1ns/1ns
module acr_sva
  import acr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] core_channel,
  input wire logic core_channel_valid,
  input wire logic core_sample
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_ready_once: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready timing");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata idle");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper");
  a_ctrl0_top: assert property (pready && !pwrite && paddr == ACR_OFF_CTRL0 |-> !prdata[7])
    else $error("ctrl0 bit7");
  a_ctrl1_gap: assert property (pready && !pwrite && paddr == ACR_OFF_CTRL1 |->
    prdata[3:2] == 2'h0)
    else $error("ctrl1 gap");
  a_chan_map: assert property (core_channel_valid == (core_channel <= 5'h0D ||
    core_channel == 5'h1D || core_channel == 5'h1F))
    else $error("channel map");
  a_start_pulse: assert property (core_sample |=> !core_sample)
    else $error("sample pulse");
  a_bad_addr: assert property (pready && paddr > ACR_OFF_STAT |-> pslverr)
    else $error("unmapped ok");
endmodule // acr_sva
bind acr_top acr_sva u_sva (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_channel(core_channel), .core_channel_valid(core_channel_valid),
  .core_sample(core_sample));

// ---- tb/test_adc_control_and_result_regs.sv ----
// testbench: apb master, comparator model, scenarios
// assumes acr_sva bound in its own file
`timescale 1ns/1ns
module test_adc_control_and_result_regs
  import acr_pkg::*;
;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, rc_clk_pin, comp_out, rerr;
  logic core_power, core_channel_valid, core_sample, conversion_done_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [4:0] core_channel;
  logic [9:0] core_trial, lvl;
  logic [1:0] core_ref_sel, rc_cnt;
  int num_errors, check_count;
  int n_samp;
  localparam logic [2:0] CKS [7] = '{3'h1, 3'h5, 3'h3, 3'h0, 3'h4, 3'h2, 3'h7};
  localparam logic [4:0] CHS [7] = '{5'h0D, 5'h1D, 5'h0E, 5'h1F, 5'h00, 5'h1E, 5'h05};
  localparam logic [9:0] LVS [7] = '{10'h2A5, 10'h15A, 10'h0C3, 10'h3A6, 10'h001,
    10'h200, 10'h1FE};
  acr_top DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_clk_pin(rc_clk_pin), .comp_out(comp_out),
    .core_power(core_power), .core_channel(core_channel),
    .core_channel_valid(core_channel_valid), .core_sample(core_sample),
    .core_trial(core_trial), .core_ref_sel(core_ref_sel),
    .conversion_done_flag(conversion_done_flag));
  acr_core_model u_core (.lvl(lvl), .core_trial(core_trial), .core_power(core_power),
    .comp_out(comp_out));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rc_cnt <= rc_cnt + 2'h1;
    rc_clk_pin <= rc_cnt[1];
  end
  always @(posedge mclk) begin
    if (core_sample === 1'b1)
      n_samp <= n_samp + 1;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
  endtask
  task automatic t_regs();
    rd_chk(ACR_OFF_CTRL0, 32'h0);
    apb(1'b1, ACR_OFF_CTRL0, 32'hFFFF_FFFF);
    rd_chk(ACR_OFF_CTRL0, 32'h7D);
    chk(32'(core_power), 32'h1);
    apb(1'b1, ACR_OFF_CTRL1, 32'hFF);
    rd_chk(ACR_OFF_CTRL1, 32'hF3);
    chk(32'(core_ref_sel), 32'h3);
    rd_chk(8'h14, 32'h0);
    chk(32'(rerr), 32'h1);
    do_reset();
    rd_chk(ACR_OFF_CTRL1, 32'h0);
    rd_chk(ACR_OFF_CTRL0, 32'h0);
    chk(32'(core_power), 32'h0);
  endtask
  task automatic t_conv(input logic [2:0] cks, input logic j, input logic [4:0] ch,
    input logic [1:0] rf, input logic [9:0] lv);
    int n;
    int s;
    lvl <= lv;
    apb(1'b1, ACR_OFF_STAT, 32'h1);
    apb(1'b1, ACR_OFF_CTRL1, {24'h0, j, cks, 2'h0, rf});
    apb(1'b1, ACR_OFF_CTRL0, {25'h0, ch, 2'h1});
    repeat (20) @(posedge mclk);
    chk(32'(core_channel_valid), 32'(ch <= 5'h0D || ch == 5'h1D || ch == 5'h1F));
    chk(32'(core_channel), 32'(ch));
    chk(32'(core_ref_sel), 32'(rf));
    s = n_samp;
    apb(1'b1, ACR_OFF_CTRL0, {25'h0, ch, 2'h3});
    n = 0;
    do begin
      apb(1'b0, ACR_OFF_CTRL0, 32'h0);
      n++;
    end while (rdat[1] !== 1'b0 && n < 300);
    chk(rdat, {25'h0, ch, 2'h1});
    chk(32'(conversion_done_flag), 32'h1);
    chk(32'(core_trial), 32'(lv));
    chk(32'(n_samp - s), 32'h1);
    rd_chk(ACR_OFF_STAT, 32'h1);
    rd_chk(ACR_OFF_RESH, j ? 32'(lv[9:8]) : 32'(lv[9:2]));
    rd_chk(ACR_OFF_RESL, j ? 32'(lv[7:0]) : {24'h0, lv[1:0], 6'h0});
    apb(1'b1, ACR_OFF_STAT, 32'h1);
    rd_chk(ACR_OFF_STAT, 32'h0);
    chk(32'(conversion_done_flag), 32'h0);
  endtask
  task automatic t_abort();
    lvl <= 10'h3FF;
    apb(1'b1, ACR_OFF_CTRL1, 32'hE0);
    apb(1'b1, ACR_OFF_CTRL0, 32'h01);
    apb(1'b1, ACR_OFF_CTRL0, 32'h03);
    repeat (150) @(posedge mclk);
    rd_chk(ACR_OFF_CTRL0, 32'h03);
    apb(1'b1, ACR_OFF_CTRL0, 32'h01);
    rd_chk(ACR_OFF_RESH, 32'h3);
    rd_chk(ACR_OFF_RESL, 32'hFF);
    rd_chk(ACR_OFF_CTRL0, 32'h01);
  endtask
  initial begin
    {psel, penable, pwrite, rc_clk_pin, paddr, pwdata, lvl, rc_cnt} = '0;
    reset = 1'b1;
    do_reset();
    t_regs();
    for (int i = 0; i < 7; i++)
      t_conv(CKS[i], i[0], CHS[i], {i[1], 1'b0}, LVS[i]);
    t_abort();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    test_done();
  end
endmodule // test_adc_control_and_result_regs
